// ### verilog/lbd_pkg.sv
// package of constants and types for the backlight dimming controller
package lbd_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int NUM_SINKS = 8;
  localparam int BRIGHT_W = 8;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_BRIGHT = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_SINK = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_DUTY = 8'h10;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_REARM_BIT = 1;
  localparam int MODE_IF_BIT = 2;
  localparam logic [7:0] BRIGHT_RST = 8'h00;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int DIM_FREQ_HZ = 210;
  localparam int DIM_STEP_CYC = CLK_HZ / (DIM_FREQ_HZ * 256);
  localparam int MIN_IN_HZ = 200;
  localparam int PERIOD_MAX_CYC = CLK_HZ / MIN_IN_HZ;
  localparam int PER_W = 17;
  localparam int CHK_US = 100;
  localparam int CHK_CYC = (CHK_US * (CLK_HZ / 1_000_000));
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LBD_DIM_INTERNAL = 2'b00,
    LBD_DIM_ANALOG   = 2'b01,
    LBD_DIM_DIRECT   = 2'b11
  } lbd_dim_e;
  typedef enum logic [1:0] {
    LBD_ST_OFF   = 2'b00,
    LBD_ST_CHECK = 2'b01,
    LBD_ST_RUN   = 2'b11
  } lbd_state_e;
  // strap level: low, high or open
  typedef enum logic [1:0] {
    LBD_PIN_LOW  = 2'b00,
    LBD_PIN_HIGH = 2'b01,
    LBD_PIN_OPEN = 2'b10
  } lbd_pin_e;
endpackage : lbd_pkg

// ### verilog/lbd_duty_meter.sv
// duty cycle meter for the incoming pwm signal
`timescale 1ns/1ps
`default_nettype none
module lbd_duty_meter #(
  parameter int PER_W = 17
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // synchronised pwm level
  input  wire logic             pwm_i,
  // result
  output logic [7:0]            duty_o,
  output logic                  done_o
);
  import lbd_pkg::*;

  typedef struct packed {
    logic [PER_W-1:0] per_cnt;
    logic [PER_W-1:0] high_cnt;
    logic             pwm_d;
    logic [7:0]       duty;
    logic             done;
  } lbd_meter_s;

  lbd_meter_s st_reg;
  lbd_meter_s st_next;
  logic [PER_W+7:0] scaled;

  // counting every clock keeps the rate fitted to any input period shorter than the all-ones per_cnt saturation
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.pwm_d = pwm_i;
    scaled = '0;
    if (pwm_i && !st_reg.pwm_d) begin
      // rising edge closes one period; result ready each period
      scaled = ({8'h00, st_reg.high_cnt} << 8) - {8'h00, st_reg.high_cnt};
      if (st_reg.per_cnt != '0) begin
        st_next.duty = 8'((scaled + {8'h00, st_reg.per_cnt >> 1}) / {8'h00, st_reg.per_cnt});
      end
      st_next.done = 1'b1;
      st_next.per_cnt = PER_W'(1);
      st_next.high_cnt = PER_W'(1);
    end else if (st_reg.per_cnt != '1) begin
      // saturation guards a stuck input; auto-ranged over the band
      st_next.per_cnt = st_reg.per_cnt + PER_W'(1);
      if (pwm_i) begin
        st_next.high_cnt = st_reg.high_cnt + PER_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign duty_o = st_reg.duty;
  assign done_o = st_reg.done;
endmodule : lbd_duty_meter
`default_nettype wire

// ### verilog/lbd_dimming_ctrl.sv
// backlight dimming controller top: straps, brightness, sinks, axi4-lite registers
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module lbd_dimming_ctrl #(
  parameter int NUM_SINKS = lbd_pkg::NUM_SINKS,
  parameter int DIM_STEP_CYC = lbd_pkg::DIM_STEP_CYC,
  parameter int CHK_CYC = lbd_pkg::CHK_CYC
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // straps, each as level plus open flag
  input  wire logic                 mode_strap_a_i,
  input  wire logic                 mode_strap_a_open_i,
  input  wire logic                 mode_strap_b_i,
  input  wire logic                 mode_strap_b_open_i,
  // pwm inputs and enable pin
  input  wire logic                 pwm_in_i,
  input  wire logic                 direct_dim_input_i,
  input  wire logic                 enable_i,
  // sink sense comparators
  input  wire logic [NUM_SINKS-1:0] sink_below_thr_i,
  input  wire logic [NUM_SINKS-1:0] sink_no_current_i,
  // sink drive
  output logic [NUM_SINKS-1:0]      led_sink_channel_o,
  output logic [7:0]                sink_level_o,
  output logic [NUM_SINKS-1:0]      sink_in_loop_o,
  // axi4-lite write address and data
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);
  import lbd_pkg::*;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic lbd_pin_e pin_level(input logic lvl, input logic is_open);
    pin_level = is_open ? LBD_PIN_OPEN : (lvl ? LBD_PIN_HIGH : LBD_PIN_LOW);
  endfunction : pin_level

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ref_addr);
    is_addr = (a[7:2] == ref_addr[7:2]);
  endfunction : is_addr

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]           a_s;
    logic [1:0]           b_s;
    logic [1:0]           ao_s;
    logic [1:0]           bo_s;
    logic [1:0]           pwm_s;
    logic [1:0]           direct_dim_input_s;
    logic [1:0]           en_s;
    logic [NUM_SINKS-1:0] thr_s1;
    logic [NUM_SINKS-1:0] thr_s2;
    logic [NUM_SINKS-1:0] nc_s1;
    logic [NUM_SINKS-1:0] nc_s2;
    lbd_dim_e             dim;
    logic                 if_smbus;
    logic                 mode_ok;
    lbd_state_e           fsm;
    logic [23:0]          chk_cnt;
    logic [NUM_SINKS-1:0] sink_act;
    logic [7:0]           bright;
    logic [15:0]          div_cnt;
    logic [7:0]           ramp;
    logic [NUM_SINKS-1:0] sink_on;
    logic [7:0]           level;
    logic                 rearm;
    logic                 aw_got;
    logic [7:0]           aw_addr;
    logic                 w_got;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
  } lbd_state_s;

  lbd_state_s st_reg;
  lbd_state_s st_next;

  logic [7:0] meas_duty;
  logic       meas_done;

  // ----------------------------------------------------------------
  // duty meter
  // ----------------------------------------------------------------
  lbd_duty_meter #(
    .PER_W (PER_W)
  ) u_meter (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pwm_i  (st_reg.pwm_s[1]),
    .duty_o (meas_duty),
    .done_o (meas_done)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    lbd_pin_e pa;
    lbd_pin_e pb;
    logic     en_rise;
    logic     dim_tick;
    pa = pin_level(st_reg.a_s[1], st_reg.ao_s[1]);
    pb = pin_level(st_reg.b_s[1], st_reg.bo_s[1]);
    en_rise = st_reg.en_s[1] && (st_reg.fsm == LBD_ST_OFF);
    st_next = st_reg;
    dim_tick = 1'b0;
    st_next.rearm = 1'b0;

    // two-flop synchronisers on all pins
    st_next.a_s = {st_reg.a_s[0], mode_strap_a_i};
    st_next.b_s = {st_reg.b_s[0], mode_strap_b_i};
    st_next.ao_s = {st_reg.ao_s[0], mode_strap_a_open_i};
    st_next.bo_s = {st_reg.bo_s[0], mode_strap_b_open_i};
    st_next.pwm_s = {st_reg.pwm_s[0], pwm_in_i};
    st_next.direct_dim_input_s = {st_reg.direct_dim_input_s[0], direct_dim_input_i};
    st_next.en_s = {st_reg.en_s[0], enable_i};
    st_next.thr_s1 = sink_below_thr_i;
    st_next.thr_s2 = st_reg.thr_s1;
    st_next.nc_s1 = sink_no_current_i;
    st_next.nc_s2 = st_reg.nc_s1;
    // strap decode, sampled while disabled so a mode never changes mid-run
    if (st_reg.fsm == LBD_ST_OFF) begin
      st_next.mode_ok = 1'b1;
      if (pa == LBD_PIN_HIGH && pb == LBD_PIN_LOW) begin
        st_next.dim = LBD_DIM_INTERNAL;
        st_next.if_smbus = 1'b1;
      end else if (pa == LBD_PIN_OPEN && pb == LBD_PIN_LOW) begin
        st_next.dim = LBD_DIM_INTERNAL;
        st_next.if_smbus = 1'b0;
      end else if (pa == LBD_PIN_LOW && pb == LBD_PIN_HIGH) begin
        st_next.dim = LBD_DIM_ANALOG;
        st_next.if_smbus = 1'b1;
      end else if (pa == LBD_PIN_LOW && pb == LBD_PIN_OPEN) begin
        st_next.dim = LBD_DIM_ANALOG;
        st_next.if_smbus = 1'b0;
      end else if (pa == LBD_PIN_LOW && pb == LBD_PIN_LOW) begin
        st_next.dim = LBD_DIM_DIRECT;
        st_next.if_smbus = 1'b0;
      end else begin
        // unlisted combination: hold sinks off
        st_next.mode_ok = 1'b0;
      end
    end

    // ----------------------------------------------------------------
    // axi4-lite slave: one outstanding write and read
    // ----------------------------------------------------------------
    if (s_axi_awvalid && !st_reg.aw_got && !st_reg.bvalid) begin
      st_next.aw_got = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_got && !st_reg.bvalid) begin
      st_next.w_got = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      if (is_addr(st_reg.aw_addr, ADDR_BRIGHT)) begin
        // host value goes straight in, pwm interface ignores it
        if (st_reg.if_smbus && st_reg.w_strb[0]) begin
          st_next.bright = st_reg.w_data[7:0];
        end
      end else if (is_addr(st_reg.aw_addr, ADDR_CTRL)) begin
        if (st_reg.w_strb[0] && st_reg.w_data[CTRL_REARM_BIT]) begin
          st_next.rearm = 1'b1;
        end
      end else if (!is_addr(st_reg.aw_addr, ADDR_MODE) && !is_addr(st_reg.aw_addr, ADDR_SINK)
                   && !is_addr(st_reg.aw_addr, ADDR_DUTY)) begin
        st_next.bresp = RESP_SLVERR;
      end
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      st_next.rdata = '0;
      if (is_addr(s_axi_araddr, ADDR_BRIGHT)) begin
        st_next.rdata[7:0] = st_reg.bright;
      end else if (is_addr(s_axi_araddr, ADDR_MODE)) begin
        st_next.rdata[1:0] = st_reg.dim;
        st_next.rdata[MODE_IF_BIT] = st_reg.if_smbus;
        st_next.rdata[3] = st_reg.mode_ok;
      end else if (is_addr(s_axi_araddr, ADDR_SINK)) begin
        st_next.rdata[NUM_SINKS-1:0] = st_reg.sink_act;
      end else if (is_addr(s_axi_araddr, ADDR_CTRL)) begin
        st_next.rdata[CTRL_EN_BIT] = (st_reg.fsm != LBD_ST_OFF);
      end else if (is_addr(s_axi_araddr, ADDR_DUTY)) begin
        st_next.rdata[7:0] = meas_duty;
      end else begin
        st_next.rresp = RESP_SLVERR;
      end
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end

    // measured duty feeds brightness on the pwm interface
    if (!st_reg.if_smbus && meas_done) begin
      st_next.bright = meas_duty;
    end

    // ----------------------------------------------------------------
    // enable sequence and unused channel detection
    // ----------------------------------------------------------------
    unique case (st_reg.fsm)
      LBD_ST_OFF: begin
        if (en_rise) begin
          // fresh enable re-arms every channel not already below threshold
          st_next.sink_act = st_reg.thr_s2 ^ {NUM_SINKS{1'b1}};
          st_next.chk_cnt = '0;
          st_next.fsm = LBD_ST_CHECK;
        end
      end
      LBD_ST_CHECK: begin
        // grounded pins keep dropping while the start-up window lasts
        st_next.sink_act = st_reg.sink_act & ~st_reg.thr_s2;
        if (st_reg.chk_cnt == 24'(CHK_CYC - 1)) begin
          // zero-current strings leave the feedback loop
          st_next.sink_act = st_reg.sink_act & ~st_reg.thr_s2 & ~st_reg.nc_s2;
          st_next.fsm = LBD_ST_RUN;
        end else begin
          st_next.chk_cnt = st_reg.chk_cnt + 24'd1;
        end
      end
      LBD_ST_RUN: begin
        if (st_reg.rearm) begin
          st_next.sink_act = {NUM_SINKS{1'b1}};
          st_next.chk_cnt = '0;
          st_next.fsm = LBD_ST_CHECK;
        end
      end
      default: begin
        st_next.fsm = LBD_ST_OFF;
      end
    endcase
    if (!st_reg.en_s[1]) begin
      st_next.fsm = LBD_ST_OFF;
    end

    // ----------------------------------------------------------------
    // dimming oscillator: 256 steps per dimming period
    // ----------------------------------------------------------------
    if (st_reg.div_cnt == 16'(DIM_STEP_CYC - 1)) begin
      st_next.div_cnt = '0;
      dim_tick = 1'b1;
    end else begin
      st_next.div_cnt = st_reg.div_cnt + 16'd1;
    end
    if (dim_tick) begin
      st_next.ramp = st_reg.ramp + 8'd1;
    end

    // ----------------------------------------------------------------
    // sink drive
    // ----------------------------------------------------------------
    st_next.sink_on = '0;
    st_next.level = '0;
    if (st_reg.fsm != LBD_ST_OFF && st_reg.mode_ok) begin
      unique case (st_reg.dim)
        LBD_DIM_INTERNAL: begin
          // own rate, register duty, all used sinks together
          if (st_reg.ramp < st_reg.bright) begin
            st_next.sink_on = st_reg.sink_act;
          end
          st_next.level = 8'hFF;
        end
        LBD_DIM_DIRECT: begin
          // input level drives sinks directly
          if (st_reg.direct_dim_input_s[1]) begin
            st_next.sink_on = st_reg.sink_act;
          end
          st_next.level = 8'hFF;
        end
        LBD_DIM_ANALOG: begin
          // always conducting, current linear in register
          st_next.sink_on = st_reg.sink_act;
          st_next.level = st_reg.bright;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0; // brightness clears, sinks off, fsm off
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign led_sink_channel_o = st_reg.sink_on;
  assign sink_level_o = st_reg.level;
  assign sink_in_loop_o = st_reg.sink_act;
  assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
  assign s_axi_wready = !st_reg.w_got && !st_reg.bvalid;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
endmodule : lbd_dimming_ctrl
`default_nettype wire

// ### tb/lbd_ctrl_sva.sv
// port assertions for the backlight dimming controller
`timescale 1ns/1ps
`default_nettype none
module lbd_ctrl_sva
  import lbd_pkg::*;
#(
  parameter int NUM_SINKS = 8
) (
  // clock, reset and pins
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 enable_i,
  input wire logic [NUM_SINKS-1:0] sink_below_thr_i,
  input wire logic [NUM_SINKS-1:0] led_sink_channel_o,
  input wire logic [NUM_SINKS-1:0] sink_in_loop_o,
  // register bus
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic [1:0]           s_axi_bresp,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic [1:0]           s_axi_rresp,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  chk_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  chk_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken");
  chk_err_zero: assert property (
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == '0)
    else $error("error read carries data");
  chk_off_dark: assert property (!enable_i [*6] |-> led_sink_channel_o == '0)
    else $error("sink on while disabled");
  // a grounded channel must be out of the loop six cycles after enable rises, inside the start-up window
  chk_low_dropped: assert property (
    $rose(enable_i) ##1 (enable_i && $stable(sink_below_thr_i)) [*6]
    |-> (sink_in_loop_o & sink_below_thr_i) == '0)
    else $error("grounded channel kept");
  cov_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  cov_sinks_on: cover property (led_sink_channel_o != '0);
  cov_drop: cover property ($rose(enable_i) && sink_below_thr_i != '0);
endmodule : lbd_ctrl_sva
`default_nettype wire

// ### tb/lbd_pwm_src.sv
// system pwm source model feeding the brightness input
`timescale 1ns/1ps
`default_nettype none
module lbd_pwm_src (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // period and high time in clock cycles
  input  wire logic [16:0] per_i,
  input  wire logic [16:0] high_i,
  output logic             pwm_o
);
  logic [16:0] cnt_reg;
  // high_i is kept between 5 and 90 percent of per_i by the bench
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 17'h0;
      pwm_o   <= 1'h0;
    end else begin
      cnt_reg <= (cnt_reg >= per_i - 17'h1) ? 17'h0 : cnt_reg + 17'h1;
      pwm_o   <= (cnt_reg < high_i);
    end
  end
endmodule : lbd_pwm_src
`default_nettype wire

// ### tb/lbd_dimming_ctrl_bench.sv
// self-checking bench for the backlight dimming controller
`timescale 1ns/1ps
`default_nettype none
module lbd_dimming_ctrl_bench;
  import lbd_pkg::*;
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        mode_strap_a_i, mode_strap_a_open_i, mode_strap_b_i, mode_strap_b_open_i;
  logic        pwm_in_i, direct_dim_input_i, enable_i, dir_on;
  logic [7:0]  sink_below_thr_i, sink_no_current_i, led_sink_channel_o, sink_level_o;
  logic [7:0]  sink_in_loop_o, s_axi_awaddr, s_axi_araddr, exp_d, used_m;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, dhist = 4'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [16:0] per_r, high_r;
  int          num_errors = 0;
  int          total_checks = 0;
  int          ons, bad;
  logic [3:0]  strap_tab [6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0, 4'hA};
  logic [3:0]  mode_tab [6] = '{4'hC, 4'h8, 4'hD, 4'h9, 4'hB, 4'h0};

  always #25 clk_i = ~clk_i;

  // short oscillator step and start-up window keep the run brief
  lbd_dimming_ctrl #(.DIM_STEP_CYC(2), .CHK_CYC(16)) i_lbd_dimming_ctrl (
    .clk_i, .rst_i, .mode_strap_a_i, .mode_strap_a_open_i, .mode_strap_b_i,
    .mode_strap_b_open_i, .pwm_in_i, .direct_dim_input_i, .enable_i, .sink_below_thr_i,
    .sink_no_current_i, .led_sink_channel_o, .sink_level_o, .sink_in_loop_o,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  lbd_pwm_src i_lbd_pwm_src (.clk_i, .rst_i, .per_i(per_r), .high_i(high_r), .pwm_o(pwm_in_i));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    do begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      n++;
      // late ready lets the response be seen waiting
      if (n == 3) s_axi_bready <= 1'h1;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
    s_axi_bready <= 1'h0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
    if (n >= 50) begin
      chk("wtimeout", 32'h0, 32'h1);
      tally_and_finish();
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                        input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      n++;
      if (n == 2) s_axi_rready <= 1'h1;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
    s_axi_rready <= 1'h0;
    chk("rdata", e & m, s_axi_rdata & m);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
    if (n >= 50) begin
      chk("rtimeout", 32'h0, 32'h1);
      tally_and_finish();
    end
  endtask : axi_rd

  task automatic set_mode(input logic [3:0] s);
    {mode_strap_a_i, mode_strap_a_open_i, mode_strap_b_i, mode_strap_b_open_i} <= s;
  endtask : set_mode

  function automatic logic [7:0] duty_of(input int h, input int p);
    return 8'((h * 255 + p / 2) / p);
  endfunction : duty_of

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // the latency may be off by one, so only settled levels are compared
  always @(posedge clk_i) begin
    dhist <= {dhist[2:0], direct_dim_input_i};
    if (dir_on && (&dhist[3:1] || !(|dhist[3:1])))
      chk("direct", 32'({8{dhist[2]}}), 32'(led_sink_channel_o));
  end

  initial begin
    void'($urandom(32'hCD15));
    {mode_strap_a_i, mode_strap_a_open_i, mode_strap_b_i, mode_strap_b_open_i} = 4'h0;
    {direct_dim_input_i, enable_i, dir_on} = 3'h0;
    {sink_below_thr_i, sink_no_current_i, s_axi_awaddr, s_axi_araddr} = 32'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {per_r, high_r} = {17'h3E8, 17'h1F4};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    axi_rd(ADDR_BRIGHT, 32'h0, 32'hFF, RESP_OKAY);
    chk("sinks", 32'h0, 32'(led_sink_channel_o));
    axi_wr(8'h40, 32'h1, RESP_SLVERR);
    axi_rd(8'h40, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    for (int i = 0; i < 6; i++) begin
      set_mode(strap_tab[i]);
      repeat (4) @(posedge clk_i);
      axi_rd(ADDR_MODE, 32'(mode_tab[i]), (i < 5) ? 32'hF : 32'h8, RESP_OKAY);
    end
    set_mode(4'h8);
    // the host write only lands once the smbus strap has been decoded
    repeat (4) @(posedge clk_i);
    sink_below_thr_i <= 8'($urandom) & 8'($urandom) & 8'hFE;
    sink_no_current_i <= 8'($urandom) & 8'($urandom) & 8'hFE;
    exp_d = 8'($urandom_range(235, 20));
    axi_wr(ADDR_BRIGHT, 32'(exp_d), RESP_OKAY);
    used_m = ~(sink_below_thr_i | sink_no_current_i);
    enable_i <= 1'h1;
    repeat (40) @(posedge clk_i);
    axi_rd(ADDR_SINK, 32'(used_m), 32'hFF, RESP_OKAY);
    {sink_below_thr_i, sink_no_current_i} <= 16'h0;
    repeat (4) @(posedge clk_i);
    axi_rd(ADDR_SINK, 32'(used_m), 32'hFF, RESP_OKAY);
    axi_wr(ADDR_CTRL, 32'h2, RESP_OKAY);
    repeat (30) @(posedge clk_i);
    axi_rd(ADDR_SINK, 32'hFF, 32'hFF, RESP_OKAY);
    axi_rd(ADDR_BRIGHT, 32'(exp_d), 32'hFF, RESP_OKAY);
    chk("level", 32'hFF, 32'(sink_level_o));
    {ons, bad} = 64'h0;
    repeat (512) begin
      @(posedge clk_i);
      ons += (led_sink_channel_o == 8'hFF);
      bad += (led_sink_channel_o != 8'hFF && led_sink_channel_o != 8'h00);
    end
    chk("mixed", 32'h0, 32'(bad));
    chk("ontime", 32'h1, 32'(ons >= 2 * exp_d - 4 && ons <= 2 * exp_d + 4));
    enable_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    set_mode(4'h1);
    repeat (6) @(posedge clk_i);
    enable_i <= 1'h1;
    for (int k = 0; k < 3; k++) begin
      per_r <= 17'($urandom_range(3000, 1000));
      @(posedge clk_i);
      high_r <= 17'($urandom_range(per_r * 9 / 10, per_r / 20));
      repeat (2 * per_r + 10) @(posedge clk_i);
      exp_d = duty_of(high_r, per_r);
      axi_rd(ADDR_DUTY, 32'(exp_d), 32'hFF, RESP_OKAY);
      chk("level", 32'(exp_d), 32'(sink_level_o));
      chk("sinks", 32'hFF, 32'(led_sink_channel_o));
      axi_wr(ADDR_BRIGHT, 32'(~exp_d), RESP_OKAY);
      chk("level", 32'(exp_d), 32'(sink_level_o));
    end
    enable_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    set_mode(4'h0);
    repeat (6) @(posedge clk_i);
    enable_i <= 1'h1;
    repeat (30) @(posedge clk_i);
    dir_on <= 1'h1;
    repeat (40) begin
      direct_dim_input_i <= 1'($urandom);
      repeat ($urandom_range(12, 3)) @(posedge clk_i);
    end
    tally_and_finish();
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    chk("timeout", 32'h0, 32'h1);
    tally_and_finish();
  end
endmodule : lbd_dimming_ctrl_bench

bind lbd_dimming_ctrl lbd_ctrl_sva #(.NUM_SINKS(NUM_SINKS)) i_lbd_ctrl_sva (
  .clk_i, .rst_i, .enable_i, .sink_below_thr_i, .led_sink_channel_o, .sink_in_loop_o,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire
